// File: shared/pldcd_regs.vh
// Constants for the pin driven LED current decoder: modes and current levels.
`ifndef PLDCD_REGS_VH
`define PLDCD_REGS_VH

// Operating mode codes.
`define PLDCD_MODE_NORMAL 2'h0
`define PLDCD_MODE_SOFT 2'h1
`define PLDCD_MODE_HARD 2'h2

// Width of a sink current level in mA.
`define PLDCD_MA_W 8

// Flash sink current per code, in mA.
`define PLDCD_FL_MA_0 8'h00
`define PLDCD_FL_MA_1 8'h1e
`define PLDCD_FL_MA_2 8'h32
`define PLDCD_FL_MA_3 8'h46
`define PLDCD_FL_MA_4 8'h5a
`define PLDCD_FL_MA_5 8'h6e
`define PLDCD_FL_MA_6 8'h82
`define PLDCD_FL_MA_7 8'h96

// General purpose sink current per code, in mA.
`define PLDCD_GP_MA_0 8'h00
`define PLDCD_GP_MA_1 8'h05
`define PLDCD_GP_MA_2 8'h07
`define PLDCD_GP_MA_3 8'h0a
`define PLDCD_GP_MA_4 8'h0c
`define PLDCD_GP_MA_5 8'h0f
`define PLDCD_GP_MA_6 8'h11
`define PLDCD_GP_MA_7 8'h25

`endif

// File: core/pldcd_sync.v
// Two flip-flop synchroniser for a group of pin levels.
`timescale 1ns/10ps
`include "pldcd_regs.vh"

module pldcd_sync #(
  parameter WIDTH = 6,
  parameter [WIDTH-1:0] INIT = {WIDTH{1'b1}}
) (
  // Clock and reset.
  input wire clk,
  input wire srst,
  // Raw and synchronised levels.
  input wire [WIDTH-1:0] din,
  output wire [WIDTH-1:0] dout
);

  reg [WIDTH-1:0] meta_ff;
  reg [WIDTH-1:0] sync_ff;

  // =========================================================
  // Synchroniser stages
  // The first stage feeds only the second stage.
  always @(posedge clk) begin
    if (srst) begin
      meta_ff <= INIT;
      sync_ff <= INIT;
    end else begin
      meta_ff <= din;
      sync_ff <= meta_ff;
    end
  end

  assign dout = sync_ff;

endmodule

// File: core/pldcd_top.v
// Mode selection and hard mode current decode for the LED sink block.
// Notes on behaviour
// - Strap high: hard mode; else soft pin picks.
// - Flash code maps to 0..150 mA, inverted.
// - One flash current drives all three sinks.
// - Backlight code maps to 0..37 mA, inverted.
// - Flash and backlight groups decode independently.
// - Normal mode: high pin or software triggers.
// - Soft mode: low pin or software triggers.
// - Code pins active low; idle pulls up.
`timescale 1ns/10ps
`include "pldcd_regs.vh"

module pldcd_top (
  // Clock and reset.
  input wire clk,
  input wire srst,
  // Mode strap.
  input wire hard_mode_strap,
  // Flash code pins, active low.
  input wire flash_code_bit2,
  input wire flash_code_bit1,
  input wire flash_code_bit0,
  // Backlight code pins, active low.
  input wire backlight_code_bit2,
  input wire backlight_code_bit1,
  input wire backlight_code_bit0,
  // Software trigger requests.
  input wire sw_flash_req,
  input wire sw_preview_req,
  // Selected mode.
  output wire [1:0] mode,
  // Trigger results for register-controlled modes.
  output wire flash_fire,
  output wire preview_start,
  // Flash sink currents in mA.
  output wire [`PLDCD_MA_W-1:0] flash_sink_a,
  output wire [`PLDCD_MA_W-1:0] flash_sink_b,
  output wire [`PLDCD_MA_W-1:0] flash_sink_c,
  // General purpose sink currents in mA.
  output wire [`PLDCD_MA_W-1:0] general_sink_a,
  output wire [`PLDCD_MA_W-1:0] general_sink_b,
  output wire [`PLDCD_MA_W-1:0] general_sink_c
);

  wire [5:0] pins_sync;
  wire [2:0] fl_code;
  wire [2:0] gp_code;
  reg [1:0] mode_ff;
  reg [1:0] nxt_mode;
  reg flash_fire_ff;
  reg nxt_flash_fire;
  reg preview_start_ff;
  reg nxt_preview_start;
  reg [`PLDCD_MA_W-1:0] flash_ma_ff;
  reg [`PLDCD_MA_W-1:0] nxt_flash_ma;
  reg [`PLDCD_MA_W-1:0] gp_ma_ff;
  reg [`PLDCD_MA_W-1:0] nxt_gp_ma;

  // =========================================================
  // Pin synchronisation
  // Idle pins reset to one, so no current flows until real levels arrive.
  pldcd_sync #(
    .WIDTH(6),
    .INIT(6'h3f)
  ) u_sync (
    .clk(clk),
    .srst(srst),
    .din({flash_code_bit2, flash_code_bit1, flash_code_bit0,
          backlight_code_bit2, backlight_code_bit1, backlight_code_bit0}),
    .dout(pins_sync)
  );

  // Each group keeps its own three pins; bit 2 is the MSB.
  assign fl_code = pins_sync[5:3];
  assign gp_code = pins_sync[2:0];

  // =========================================================
  // Mode selection
  // The soft pin shares the flash bit 1 pin and is only read with the strap low.
  always @* begin
    if (hard_mode_strap) begin
      nxt_mode = `PLDCD_MODE_HARD;
    end else if (pins_sync[4]) begin
      nxt_mode = `PLDCD_MODE_SOFT;
    end else begin
      nxt_mode = `PLDCD_MODE_NORMAL;
    end
  end

  // =========================================================
  // Trigger polarity
  // Flash trigger shares flash bit 2; preview shares backlight bit 0.
  always @* begin
    nxt_flash_fire = 1'b0;
    nxt_preview_start = 1'b0;
    case (mode_ff)
      `PLDCD_MODE_NORMAL: begin
        nxt_flash_fire = pins_sync[5] | sw_flash_req;
        nxt_preview_start = pins_sync[0] | sw_preview_req;
      end
      `PLDCD_MODE_SOFT: begin
        nxt_flash_fire = ~pins_sync[5] | sw_flash_req;
        nxt_preview_start = ~pins_sync[0] | sw_preview_req;
      end
      default: begin
        nxt_flash_fire = 1'b0;
        nxt_preview_start = 1'b0;
      end
    endcase
  end

  // =========================================================
  // Flash current decode, active low code
  always @* begin
    case (fl_code)
      3'h7: nxt_flash_ma = `PLDCD_FL_MA_0;
      3'h6: nxt_flash_ma = `PLDCD_FL_MA_1;
      3'h5: nxt_flash_ma = `PLDCD_FL_MA_2;
      3'h4: nxt_flash_ma = `PLDCD_FL_MA_3;
      3'h3: nxt_flash_ma = `PLDCD_FL_MA_4;
      3'h2: nxt_flash_ma = `PLDCD_FL_MA_5;
      3'h1: nxt_flash_ma = `PLDCD_FL_MA_6;
      3'h0: nxt_flash_ma = `PLDCD_FL_MA_7;
      default: nxt_flash_ma = `PLDCD_FL_MA_0;
    endcase
  end

  // =========================================================
  // Backlight current decode, active low code
  always @* begin
    case (gp_code)
      3'h7: nxt_gp_ma = `PLDCD_GP_MA_0;
      3'h6: nxt_gp_ma = `PLDCD_GP_MA_1;
      3'h5: nxt_gp_ma = `PLDCD_GP_MA_2;
      3'h4: nxt_gp_ma = `PLDCD_GP_MA_3;
      3'h3: nxt_gp_ma = `PLDCD_GP_MA_4;
      3'h2: nxt_gp_ma = `PLDCD_GP_MA_5;
      3'h1: nxt_gp_ma = `PLDCD_GP_MA_6;
      3'h0: nxt_gp_ma = `PLDCD_GP_MA_7;
      default: nxt_gp_ma = `PLDCD_GP_MA_0;
    endcase
  end

  // =========================================================
  // Output registers
  // Currents apply only in hard mode and follow the code with no latch.
  always @(posedge clk) begin
    if (srst) begin
      mode_ff <= `PLDCD_MODE_NORMAL;
      flash_fire_ff <= 1'b0;
      preview_start_ff <= 1'b0;
      flash_ma_ff <= `PLDCD_FL_MA_0;
      gp_ma_ff <= `PLDCD_GP_MA_0;
    end else begin
      mode_ff <= nxt_mode;
      flash_fire_ff <= nxt_flash_fire;
      preview_start_ff <= nxt_preview_start;
      flash_ma_ff <= (nxt_mode == `PLDCD_MODE_HARD) ? nxt_flash_ma : `PLDCD_FL_MA_0;
      gp_ma_ff <= (nxt_mode == `PLDCD_MODE_HARD) ? nxt_gp_ma : `PLDCD_GP_MA_0;
    end
  end

  assign mode = mode_ff;
  assign flash_fire = flash_fire_ff;
  assign preview_start = preview_start_ff;

  // One decoded level drives the whole flash block.
  assign flash_sink_a = flash_ma_ff;
  assign flash_sink_b = flash_ma_ff;
  assign flash_sink_c = flash_ma_ff;
  assign general_sink_a = gp_ma_ff;
  assign general_sink_b = gp_ma_ff;
  assign general_sink_c = gp_ma_ff;

endmodule

// File: tb/pldcd_host.sv
// Host model that drives the six code pins as static levels.
`timescale 1ns/10ps
module pldcd_host (
  // Clock and drive request.
  input wire clk,
  input wire drive,
  input wire [5:0] code,
  // Code pins, flash_code_bit2 in bit 5.
  output reg [5:0] pins
);
  // Released pins float to one through the internal pull-ups.
  initial pins = 6'h3f;
  always @(posedge clk) pins <= #1 drive ? code : 6'h3f;
endmodule

// File: tb/pldcd_top_properties.sv
// Port checks for the LED current decoder, bound to its top module.
`timescale 1ns/10ps
`include "pldcd_regs.vh"
module pldcd_props (
  // Clock, reset and inputs.
  input wire clk,
  input wire srst,
  input wire hard_mode_strap,
  input wire sw_flash_req,
  input wire flash_code_bit2,
  input wire flash_code_bit1,
  input wire flash_code_bit0,
  input wire backlight_code_bit2,
  input wire backlight_code_bit1,
  input wire backlight_code_bit0,
  // Outputs under check.
  input wire [1:0] mode,
  input wire flash_fire,
  input wire [`PLDCD_MA_W-1:0] flash_sink_a,
  input wire [`PLDCD_MA_W-1:0] flash_sink_c,
  input wire [`PLDCD_MA_W-1:0] general_sink_a,
  input wire [`PLDCD_MA_W-1:0] general_sink_c
);
  int fl[8] = '{0, 30, 50, 70, 90, 110, 130, 150};
  int gl[8] = '{0, 5, 7, 10, 12, 15, 17, 37};
  wire [2:0] nf = ~{flash_code_bit2, flash_code_bit1, flash_code_bit0};
  wire [2:0] ng = ~{backlight_code_bit2, backlight_code_bit1, backlight_code_bit0};
  wire hard = mode == `PLDCD_MODE_HARD;
  reg [1:0] age_ff;
  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);
  // Counts edges since reset up to three, once the synchroniser holds real levels.
  always @(posedge clk) age_ff <= srst ? 2'h0 : age_ff + {1'b0, age_ff != 2'h3};
  property p_strap; hard_mode_strap |=> hard; endproperty
  a_strap: assert property (p_strap) else $error("strap ignored");
  property p_off; !hard |-> flash_sink_a == 8'h00 && general_sink_a == 8'h00; endproperty
  a_off: assert property (p_off) else $error("current outside hard mode");
  property p_fl; age_ff == 2'h3 && hard |-> flash_sink_a == fl[$past(nf, 3)]; endproperty
  a_fl: assert property (p_fl) else $error("flash current wrong");
  property p_gl; age_ff == 2'h3 && hard |-> general_sink_a == gl[$past(ng, 3)]; endproperty
  a_gl: assert property (p_gl) else $error("general current wrong");
  property p_fl_same; flash_sink_a == flash_sink_c; endproperty
  a_fl_same: assert property (p_fl_same) else $error("flash sinks differ");
  property p_gl_same; general_sink_a == general_sink_c; endproperty
  a_gl_same: assert property (p_gl_same) else $error("general sinks differ");
  property p_quiet; hard && $past(hard) |-> !flash_fire; endproperty
  a_quiet: assert property (p_quiet) else $error("fire in hard mode");
  property p_sw; !hard && sw_flash_req |=> flash_fire; endproperty
  a_sw: assert property (p_sw) else $error("software fire lost");
endmodule
bind pldcd_top pldcd_props chk (.*);

// File: tb/tb_pin_driven_led_current_decoder.sv
// Self-checking bench for the LED current decoder with a pin host model.
`timescale 1ns/10ps
`include "pldcd_regs.vh"
module tb_pin_driven_led_current_decoder;
  reg clk = 0, srst = 1, strap = 0, drive = 1, swf = 0, swp = 0;
  reg [5:0] code = 6'h3f;
  reg [31:0] lfsr = 32'h4efe57d3;
  wire [5:0] pins;
  wire [1:0] mode;
  wire ff, ps;
  wire [7:0] fa, fb, fc, ga, gb, gc;
  int errors = 0, checks = 0;
  int fl[8] = '{0, 30, 50, 70, 90, 110, 130, 150};
  int gl[8] = '{0, 5, 7, 10, 12, 15, 17, 37};
  // The clock toggles every half period of 25 ns.
  always #25 clk = ~clk;
  pldcd_host host (.clk(clk), .drive(drive), .code(code), .pins(pins));
  pldcd_top DUT (.clk(clk), .srst(srst), .hard_mode_strap(strap), .flash_code_bit2(pins[5]),
    .flash_code_bit1(pins[4]), .flash_code_bit0(pins[3]), .backlight_code_bit2(pins[2]),
    .backlight_code_bit1(pins[1]), .backlight_code_bit0(pins[0]), .sw_flash_req(swf),
    .sw_preview_req(swp), .mode(mode), .flash_fire(ff), .preview_start(ps), .flash_sink_a(fa),
    .flash_sink_b(fb), .flash_sink_c(fc), .general_sink_a(ga), .general_sink_b(gb),
    .general_sink_c(gc));
  task chk(input string nm, input logic [47:0] seen, input logic [47:0] exp);
    checks++;
    if (seen !== exp) begin
      errors++;
      $display("ERROR %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  // Applies pins and requests, lets them settle, then compares with the tables.
  task run(input [5:0] c, input [1:0] s, m, t, input int nf, ng);
    {swf, swp} = s;
    code = c;
    repeat (6) @(posedge clk);
    #1;
    chk("mode and triggers", {mode, ff, ps}, {m, t});
    chk("sinks", {fa, fb, fc, ga, gb, gc}, {fl[nf][7:0], fl[nf][7:0], fl[nf][7:0],
      gl[ng][7:0], gl[ng][7:0], gl[ng][7:0]});
  endtask
  function [31:0] nxt_rand(input [31:0] v);
    nxt_rand = {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
  endfunction
  task end_of_test;
    $display("errors %0d checks %0d", errors, checks);
    if (errors == 0 && checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  // Hard mode over every code pair, pins released, then normal and soft triggers.
  initial begin
    repeat (8) @(posedge clk);
    #1;
    srst = 0;
    strap = 1;
    for (int i = 0; i < 64; i++) begin
      lfsr = nxt_rand(lfsr);
      run(i[5:0], lfsr[1:0], 2'h2, 2'h0, 7 - i / 8, 7 - i % 8);
    end
    drive = 0;
    run(6'h00, 2'h0, 2'h2, 2'h0, 0, 0);
    drive = 1;
    strap = 0;
    run(6'h29, 2'h0, 2'h0, 2'h3, 0, 0);
    run(6'h08, 2'h3, 2'h0, 2'h3, 0, 0);
    run(6'h08, 2'h0, 2'h0, 2'h0, 0, 0);
    run(6'h16, 2'h0, 2'h1, 2'h3, 0, 0);
    run(6'h37, 2'h1, 2'h1, 2'h1, 0, 0);
    end_of_test;
  end
  // Cuts a hang short well past the expected run of about 430 cycles.
  initial begin
    #100000;
    errors++;
    end_of_test;
  end
endmodule
